// ---- design/gcsrmb_pkg.sv ----
/*
  constants, field positions, reset values and the access carrier type for the
  global control/status, semaphore and mailbox block.
  assumes a single 250 MHz device clock and no imports by users.
*/
// Functional notes
// - local reset output held active while reset bit set; minimum pulse always kept.
// - system fail output asserted only when enable set and board fail active.
// - system fail enable reset value taken from a strap sampled at reset release.
// - board fail status is read-only, the inverse of the active-low board fail input pin.
// - system controller status is read-only, one when controller function enabled.
// - module ready is read/write, cleared by reset; software sets it when ready.
// - bits 23:20 show location monitor pending flags, monitor 0 at bit 20.
// - bits 19:16 show mailbox pending flags, mailbox 0 at bit 16.
// - bit 13 is inverted slot parity pin; bits 15:14 read zero.
// - bits 12:8 are inverted five-bit slot address pins.
// - low byte is a read-only revision code that writes never change.
// - semaphore byte takes a write if data top bit clear or stored top clear.
// - eight semaphore bytes, four per word, lowest number in top byte; reset zero.
// - writing a mailbox low byte raises that mailbox's interrupt request.
// - four 32-bit read/write mailboxes, reset to zero.
// - each register reached at window offset and at 0x600 plus offset locally.
// - the register group is reachable from both the local and the remote bus.
package gcsrmb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets within the window
  localparam logic [4:0]  OFS_ID       = 5'h00;
  localparam logic [4:0]  OFS_CTRL     = 5'h04;
  localparam logic [4:0]  OFS_SEM_LO   = 5'h08;
  localparam logic [4:0]  OFS_SEM_HI   = 5'h0c;
  localparam logic [4:0]  OFS_MAILBOX_0    = 5'h10;
  localparam logic [4:0]  OFS_MAILBOX_1    = 5'h14;
  localparam logic [4:0]  OFS_MAILBOX_2    = 5'h18;
  localparam logic [4:0]  OFS_MAILBOX_3    = 5'h1c;
  localparam logic [11:0] LOCAL_BASE   = 12'h600;

  ////////////////////////////////////////////////////////////////////////////
  // control/status field positions
  localparam int BIT_LOCAL_RESET_CTL    = 31;
  localparam int BIT_SFAIL   = 30;
  localparam int BIT_BOARD_FAIL_IN_N  = 29;
  localparam int BIT_SYSCON  = 28;
  localparam int BIT_READY   = 27;
  localparam int LOCMON_LSB  = 20;
  localparam int MAILBOX_WORD_LSB    = 16;
  localparam int BIT_GAP     = 13;
  localparam int GA_LSB      = 8;
  localparam int SEM_TOP     = 7;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] SEM_RST    = 32'h0000_0000;
  localparam logic [31:0] MAILBOX_WORD_RST   = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // local reset minimum pulse
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RST_MIN_NS    = 1000;
  localparam int RST_MIN_CYC   = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CNT_W     = 9;

  // one access request on either port
  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } gcsrmb_req_t;

endpackage : gcsrmb_pkg

// ---- design/gcsrmb_sem_lane.sv ----
/*
  one byte-wide hardware semaphore with its acceptance test.
  assumes at most one write strobe per cycle from the serialised access path.
*/
`timescale 1ns/1ps
`default_nettype none
module gcsrmb_sem_lane
(
  // clock and reset
  input  wire  logic       ref_clk,
  input  wire  logic       resetn,
  // write strobe for this byte lane
  input  wire  logic       we,
  input  wire  logic [7:0] wdata,
  // stored semaphore
  output var   logic [7:0] value
);

  logic       accept;
  logic [7:0] next_value;

  ////////////////////////////////////////////////////////////////////////////
  // take the write unless both top bits are set
  always_comb
  begin
    accept     = we && (!wdata[gcsrmb_pkg::SEM_TOP] || !value[gcsrmb_pkg::SEM_TOP]);
    next_value = accept ? wdata : value;
  end

  // register the semaphore
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      value <= gcsrmb_pkg::BYTE_RST;
    else
      value <= next_value;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_sem_held: assert property (we && wdata[7] && value[7] |=> $stable(value))
    else $error("owned semaphore overwritten");
  a_sem_taken: assert property (we && !(wdata[7] && value[7]) |=> value == $past(wdata))
    else $error("semaphore write not taken");

endmodule : gcsrmb_sem_lane
`default_nettype wire

// ---- design/gcsrmb_top.sv ----
/*
  global control/status, semaphores and mailboxes, reached from the local
  configuration space port and from the remote bus window port.
  assumes both ports are synchronous to ref_clk and hold req until their ack.
*/
`timescale 1ns/1ps
`default_nettype none
module gcsrmb_top
#(
  parameter logic [7:0]  REV_CODE = 8'h5a,         // arbitrary value
  parameter logic [31:0] ID_CODE  = 32'h1234_abcd  // arbitrary value
)
(
  // clock and resets
  input  wire  logic                    ref_clk,
  input  wire  logic                    resetn,
  input  wire  logic                    local_rst_n,
  // local configuration space port
  input  wire  gcsrmb_pkg::gcsrmb_req_t loc_port,
  output var   logic                    loc_ack,
  // remote bus window port
  input  wire  gcsrmb_pkg::gcsrmb_req_t vme_port,
  output var   logic                    vme_ack,
  // shared read data
  output var   logic [31:0]             rdata,
  // board pins and straps
  input  wire  logic                    board_fail_in_n,
  input  wire  logic                    sfail_en_strap,
  input  wire  logic                    syscon_en,
  input  wire  logic [4:0]              ga_n,
  input  wire  logic                    gap_n,
  output var   logic                    sysfail_out,
  output var   logic                    local_reset_out_n,
  // interrupt logic side
  input  wire  logic [3:0]              locmon_event,
  input  wire  logic [3:0]              locmon_clr,
  input  wire  logic [3:0]              mailbox_word_clr,
  output var   logic [3:0]              mailbox_word_irq_req
);

  localparam logic [8:0] RST_LOAD = 9'(gcsrmb_pkg::RST_MIN_CYC - 1);

  // access path
  logic                    take_loc;
  logic                    take_vme;
  gcsrmb_pkg::gcsrmb_req_t cur;
  logic                    hit;
  logic [4:0]              ofs;
  logic                    wr;
  logic                    rd_ok;
  logic [31:0]             rd;
  logic                    next_loc_ack;
  logic                    next_vme_ack;
  logic [31:0]             next_rdata;
  // control state
  logic                    local_reset_ctl;
  logic                    sfail_en;
  logic                    strap_done;
  logic                    module_ready;
  logic [3:0]              locmon_pend;
  logic [3:0]              mailbox_word_pend;
  logic [8:0]              rst_cnt;
  logic                    next_local_reset_ctl;
  logic                    next_sfail_en;
  logic                    next_module_ready;
  logic [3:0]              next_locmon_pend;
  logic [3:0]              next_mailbox_word_pend;
  logic [8:0]              next_rst_cnt;
  logic                    next_sysfail_out;
  logic                    next_local_reset_out_n;
  logic [3:0]              mailbox_word_set;
  logic [31:0]             ctrl_word;
  // storage
  logic [31:0]             sem_lo;
  logic [31:0]             sem_hi;
  logic [31:0]             mailbox_word [4];
  logic [31:0]             next_mailbox_word [4];

  ////////////////////////////////////////////////////////////////////////////
  // serialise the two ports, local first, one access per cycle
  always_comb
  begin
    take_loc = loc_port.req && !loc_ack;
    take_vme = vme_port.req && !vme_ack && !take_loc;
    cur      = take_loc ? loc_port : vme_port;
    ofs      = cur.addr[4:0];
    // alias decode: local at base plus offset, window at offset
    if (take_loc)
      hit = (cur.addr[11:5] == gcsrmb_pkg::LOCAL_BASE[11:5]);
    else
      hit = take_vme && (cur.addr[11:5] == 7'h00);
    wr    = hit && cur.we;
    rd_ok = hit && !cur.we;
  end

  // control word as read back
  always_comb
  begin
    ctrl_word                                    = 32'h0000_0000;
    ctrl_word[gcsrmb_pkg::BIT_LOCAL_RESET_CTL]              = local_reset_ctl;
    ctrl_word[gcsrmb_pkg::BIT_SFAIL]             = sfail_en;
    ctrl_word[gcsrmb_pkg::BIT_BOARD_FAIL_IN_N]            = !board_fail_in_n;
    ctrl_word[gcsrmb_pkg::BIT_SYSCON]            = syscon_en;
    ctrl_word[gcsrmb_pkg::BIT_READY]             = module_ready;
    ctrl_word[gcsrmb_pkg::LOCMON_LSB +: 4]       = locmon_pend;
    ctrl_word[gcsrmb_pkg::MAILBOX_WORD_LSB +: 4]         = mailbox_word_pend;
    ctrl_word[gcsrmb_pkg::BIT_GAP]               = !gap_n;
    ctrl_word[gcsrmb_pkg::GA_LSB +: 5]           = ~ga_n;
    ctrl_word[7:0]                               = REV_CODE;
  end

  // read mux, unmapped offsets read zero
  always_comb
  begin
    case (ofs)
      gcsrmb_pkg::OFS_ID:     rd = ID_CODE;
      gcsrmb_pkg::OFS_CTRL:   rd = ctrl_word;
      gcsrmb_pkg::OFS_SEM_LO: rd = sem_lo;
      gcsrmb_pkg::OFS_SEM_HI: rd = sem_hi;
      gcsrmb_pkg::OFS_MAILBOX_0:  rd = mailbox_word[0];
      gcsrmb_pkg::OFS_MAILBOX_1:  rd = mailbox_word[1];
      gcsrmb_pkg::OFS_MAILBOX_2:  rd = mailbox_word[2];
      gcsrmb_pkg::OFS_MAILBOX_3:  rd = mailbox_word[3];
      default:                rd = 32'h0000_0000;
    endcase
    next_loc_ack = take_loc;
    next_vme_ack = take_vme;
    if (take_loc || take_vme)
      next_rdata = rd_ok ? rd : 32'h0000_0000;
    else
      next_rdata = rdata;
  end

  // register the answer
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loc_ack <= 1'b0;
      vme_ack <= 1'b0;
      rdata   <= 32'h0000_0000;
    end
    else
    begin
      loc_ack <= next_loc_ack;
      vme_ack <= next_vme_ack;
      rdata   <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // semaphores: lane i sits in word i/4, byte 3 - i%4
  for (genvar i = 0; i < 8; i++)
  begin : g_sem
    localparam int BYTE = 3 - (i % 4);
    logic [7:0] value;
    logic       lane_we;
    // per lane strobe from the matching byte enable
    assign lane_we = wr && cur.be[BYTE] &&
                     (ofs == ((i < 4) ? gcsrmb_pkg::OFS_SEM_LO : gcsrmb_pkg::OFS_SEM_HI));
    gcsrmb_sem_lane u_lane
    (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .we      (lane_we),
      .wdata   (cur.wdata[BYTE*8 +: 8]),
      .value   (value)
    );
    // pack into the read words, semaphore 0 at the top
    if (i < 4)
    begin : g_lo
      assign sem_lo[BYTE*8 +: 8] = value;
    end
    else
    begin : g_hi
      assign sem_hi[BYTE*8 +: 8] = value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mailboxes, byte writes, low byte raises the request
  always_comb
  begin
    for (int m = 0; m < 4; m++)
    begin
      next_mailbox_word[m] = mailbox_word[m];
      mailbox_word_set[m]  = 1'b0;
      if (wr && ofs == 5'(gcsrmb_pkg::OFS_MAILBOX_0 + 5'(m * 4)))
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (cur.be[b])
            next_mailbox_word[m][b*8 +: 8] = cur.wdata[b*8 +: 8];
        end
        mailbox_word_set[m] = cur.be[0];
      end
    end
  end

  // register the mailboxes
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int m = 0; m < 4; m++)
        mailbox_word[m] <= gcsrmb_pkg::MAILBOX_WORD_RST;
      mailbox_word_irq_req <= 4'h0;
    end
    else
    begin
      for (int m = 0; m < 4; m++)
        mailbox_word[m] <= next_mailbox_word[m];
      mailbox_word_irq_req <= mailbox_word_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits, pending flags, local reset stretch, system fail
  always_comb
  begin
    next_local_reset_ctl         = local_reset_ctl;
    next_sfail_en     = sfail_en;
    next_module_ready = module_ready;
    if (!strap_done)
      next_sfail_en = sfail_en_strap;
    if (wr && ofs == gcsrmb_pkg::OFS_CTRL && cur.be[3])
    begin
      next_local_reset_ctl         = cur.wdata[gcsrmb_pkg::BIT_LOCAL_RESET_CTL];
      next_module_ready = cur.wdata[gcsrmb_pkg::BIT_READY];
      if (strap_done)
        next_sfail_en = cur.wdata[gcsrmb_pkg::BIT_SFAIL];
    end
    // set wins over clear
    next_locmon_pend = (locmon_pend & ~locmon_clr) | locmon_event;
    next_mailbox_word_pend   = (mailbox_word_pend & ~mailbox_word_clr) | mailbox_word_set;
    if (!local_rst_n)
    begin
      next_module_ready = 1'b0;
      next_locmon_pend  = 4'h0;
      next_mailbox_word_pend    = 4'h0;
    end
    // hold the count full while the bit is set, then run it down
    if (local_reset_ctl)
      next_rst_cnt = RST_LOAD;
    else if (rst_cnt != 9'h000)
      next_rst_cnt = rst_cnt - 9'h001;
    else
      next_rst_cnt = rst_cnt;
    next_local_reset_out_n = !(local_reset_ctl || rst_cnt != 9'h000);
    next_sysfail_out       = sfail_en && !board_fail_in_n;
  end

  // register control state
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      local_reset_ctl              <= 1'b0;
      sfail_en          <= 1'b0;
      strap_done        <= 1'b0;
      module_ready      <= 1'b0;
      locmon_pend       <= 4'h0;
      mailbox_word_pend         <= 4'h0;
      rst_cnt           <= 9'h000;
      sysfail_out       <= 1'b0;
      local_reset_out_n <= 1'b1;
    end
    else
    begin
      local_reset_ctl              <= next_local_reset_ctl;
      sfail_en          <= next_sfail_en;
      strap_done        <= 1'b1;
      module_ready      <= next_module_ready;
      locmon_pend       <= next_locmon_pend;
      mailbox_word_pend         <= next_mailbox_word_pend;
      rst_cnt           <= next_rst_cnt;
      sysfail_out       <= next_sysfail_out;
      local_reset_out_n <= next_local_reset_out_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int RST_MIN = gcsrmb_pkg::RST_MIN_CYC;
  logic [8:0] low_cnt;

  // count cycles the local reset output has been low
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      low_cnt <= 9'h000;
    else if (local_reset_out_n)
      low_cnt <= 9'h000;
    else if (low_cnt != 9'h1ff)
      low_cnt <= low_cnt + 9'h001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_both_req;
    loc_port.req && vme_port.req && !loc_ack && !vme_ack;
  endsequence
  sequence s_loc_then_vme;
    loc_ack && !vme_ack ##1 vme_ack && !loc_ack;
  endsequence

  a_reset_hold: assert property (local_reset_ctl |=> !local_reset_out_n)
    else $error("local reset output not active");
  a_reset_width: assert property ($rose(local_reset_out_n) |-> low_cnt >= RST_MIN - 1)
    else $error("local reset pulse too short");
  a_sysfail_off: assert property (!sfail_en |=> !sysfail_out)
    else $error("system fail driven while disabled");
  a_sysfail_on: assert property (sfail_en && !board_fail_in_n |=> sysfail_out)
    else $error("system fail not driven");
  a_ready_clear: assert property (!local_rst_n |=> !module_ready && mailbox_word_pend == 4'h0)
    else $error("local reset did not clear state");
  a_mailbox_word_irq: assert property (wr && ofs == gcsrmb_pkg::OFS_MAILBOX_2 && cur.be[0]
                               |=> mailbox_word_irq_req[2] && (mailbox_word_pend[2] || $past(!local_rst_n)))
    else $error("mailbox request missing");
  a_serial_order: assert property (s_both_req |=> s_loc_then_vme)
    else $error("ports not served in turn");
  a_rev_read: assert property (rd_ok && ofs == gcsrmb_pkg::OFS_CTRL
                               |=> rdata[7:0] == REV_CODE && rdata[12:8] == ~$past(ga_n))
    else $error("control read wrong");
  a_status_bits: assert property (rd_ok && ofs == gcsrmb_pkg::OFS_CTRL
                                  |=> rdata[15:14] == 2'b00
                                      && rdata[29] == !$past(board_fail_in_n))
    else $error("status bits wrong");

endmodule : gcsrmb_top
`default_nettype wire

// ---- sim/gcsrmb_bus_master.sv ----
/*
  software-side bus master model: one access at a time on either access port.
  assumes the caller runs in step with ref_clk; the port's ack is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module gcsrmb_bus_master
(
  // clock
  input  wire logic                    ref_clk,
  // access port toward the block
  output var  gcsrmb_pkg::gcsrmb_req_t port,
  input  wire logic                    ack,
  input  wire logic [31:0]             rdata
);
  initial port = '0;

  //////////////////////////////////////////////////////////////////////////////
  // launch, hold until ack, take data, release; plain accesses only
  task automatic access(input logic we, input logic [11:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    port <= '{1'b1, we, addr, be, wdata};
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rd = (ack === 1'b1) ? rdata : 32'hxxxx_xxxx; // no answer reads as unknown
    // released lines no longer show the old data
    @(posedge ref_clk);
    port <= '{1'b0, 1'b0, ~addr, 4'h0, ~wdata};
  endtask : access
endmodule : gcsrmb_bus_master
`default_nettype wire

// ---- sim/gcsrmb_top_tb.sv ----
/*
  self-checking bench for the control/status, semaphore and mailbox block.
  assumes the block's ports as declared and one 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module gcsrmb_top_tb;
  localparam logic [7:0] REV = 8'h3c;  // arbitrary value

  logic                    ref_clk, resetn, local_rst_n, bf_n, strap, syscon, gap_n;
  logic [4:0]              ga_n;
  logic [3:0]              lm_ev, lm_clr, mb_clr, mailbox_word_irq_req;
  logic                    loc_ack, vme_ack, sysfail_out, local_reset_out_n;
  logic [31:0]             rdata;
  gcsrmb_pkg::gcsrmb_req_t loc_port, vme_port;
  int                      failures, checks;
  int                      irq_cnt [4];

  //////////////////////////////////////////////////////////////////////////////
  // block and its two software-side masters
  gcsrmb_top #(.REV_CODE(REV), .ID_CODE(32'h0bad_f00d)) u_gcsrmb_top (
    .ref_clk(ref_clk), .resetn(resetn), .local_rst_n(local_rst_n),
    .loc_port(loc_port), .loc_ack(loc_ack), .vme_port(vme_port), .vme_ack(vme_ack),
    .rdata(rdata), .board_fail_in_n(bf_n), .sfail_en_strap(strap), .syscon_en(syscon),
    .ga_n(ga_n), .gap_n(gap_n), .sysfail_out(sysfail_out),
    .local_reset_out_n(local_reset_out_n), .locmon_event(lm_ev), .locmon_clr(lm_clr),
    .mailbox_word_clr(mb_clr), .mailbox_word_irq_req(mailbox_word_irq_req));
  gcsrmb_bus_master u_loc (.ref_clk(ref_clk), .port(loc_port), .ack(loc_ack), .rdata(rdata));
  gcsrmb_bus_master u_vme (.ref_clk(ref_clk), .port(vme_port), .ack(vme_ack), .rdata(rdata));

  // clock and mailbox request counters
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    for (int i = 0; i < 4; i++)
      irq_cnt[i] += int'(mailbox_word_irq_req[i] === 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // compare, access and closing tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input bit v, input logic [11:0] ofs, input logic [3:0] be,
                    input logic [31:0] d);
    logic [31:0] x;
    if (v)
      u_vme.access(1'b1, ofs, be, d, x);
    else
      u_loc.access(1'b1, 12'h600 + ofs, be, d, x);
  endtask : wr

  task automatic rc(input bit v, input logic [11:0] ofs, input logic [31:0] exp,
                    input string what);
    logic [31:0] x;
    if (v)
      u_vme.access(1'b0, ofs, 4'hf, 32'h0, x);
    else
      u_loc.access(1'b0, 12'h600 + ofs, 4'hf, 32'h0, x);
    chk(what, x, exp);
  endtask : rc

  function automatic logic [31:0] ctl(input logic lr, sf, rdy, input logic [3:0] lm, mb);
    return {lr, sf, ~bf_n, syscon, rdy, 3'h0, lm, mb, 2'h0, ~gap_n, ~ga_n, REV};
  endfunction : ctl

  task automatic pulse(input bit lm, input logic [3:0] v);
    @(posedge ref_clk);
    if (lm)
      lm_ev <= v;
    else
      mb_clr <= v;
    @(posedge ref_clk);
    lm_ev  <= 4'h0;
    mb_clr <= 4'h0;
  endtask : pulse

  task automatic do_reset(input logic st);
    @(posedge ref_clk);
    resetn <= 1'b0;
    strap  <= st;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
  endtask : do_reset

  task automatic wrap_up;
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  //////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    {resetn, local_rst_n, bf_n, strap, syscon, gap_n} = 6'b011110;
    ga_n = 5'h1a;
    {lm_ev, lm_clr, mb_clr} = '0;
    do_reset(1'b1);
    for (int i = 2; i < 8; i++)
      rc(i[0], 12'(4 * i), 32'h0, "reset word");
    rc(1'b1, 12'h20, 32'h0, "unmapped remote");
    rc(1'b0, 12'h20, 32'h0, "unmapped local");
    rc(1'b0, 12'h4, ctl(0, 1, 0, 4'h0, 4'h0), "ctrl reset");
    // mailboxes through both ports
    for (int i = 0; i < 4; i++)
      wr(i[0], 12'(16 + 4 * i), 4'hf, 32'h5a00_0000 + i);
    for (int i = 0; i < 4; i++)
      rc(!i[0], 12'(16 + 4 * i), 32'h5a00_0000 + i, "mailbox");
    for (int i = 0; i < 4; i++)
      chk("mailbox request", irq_cnt[i], 32'h1);
    rc(1'b0, 12'h4, ctl(0, 1, 0, 4'h0, 4'hf), "mailbox_word pending");
    wr(1'b0, 12'h10, 4'he, 32'h0);
    pulse(1'b0, 4'hf);
    chk("no low byte request", irq_cnt[0], 32'h1);
    wr(1'b1, 12'h14, 4'h1, 32'h77);
    pulse(1'b1, 4'h4);
    wr(1'b0, 12'h4, 4'hf, 32'h4fff_ffff);
    rc(1'b0, 12'h4, ctl(0, 1, 1, 4'h4, 4'h2), "ctrl bits");
    // local reset clears ready and pending only
    @(posedge ref_clk);
    local_rst_n <= 1'b0;
    @(posedge ref_clk);
    local_rst_n <= 1'b1;
    rc(1'b1, 12'h4, ctl(0, 1, 0, 4'h0, 4'h0), "after local reset");
    rc(1'b0, 12'h14, 32'h5a00_0077, "mailbox kept");
    // board fail, system fail and board pins
    @(posedge ref_clk);
    bf_n  <= 1'b0;
    ga_n  <= 5'h05;
    gap_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("sysfail on", sysfail_out, 32'h1);
    rc(1'b0, 12'h4, ctl(0, 1, 0, 4'h0, 4'h0), "board fail");
    wr(1'b1, 12'h4, 4'h8, 32'h0);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("sysfail off", sysfail_out, 32'h0);
    @(posedge ref_clk);
    bf_n   <= 1'b1;
    syscon <= 1'b0;
    @(posedge ref_clk);
    rc(1'b1, 12'h4, ctl(0, 0, 0, 4'h0, 4'h0), "syscon");
    // semaphore acceptance per lane
    wr(1'b0, 12'h8, 4'h8, 32'h8100_0000);
    wr(1'b1, 12'h8, 4'h8, 32'hff00_0000);
    wr(1'b0, 12'h8, 4'hf, 32'h9a92_7f80);
    rc(1'b1, 12'h8, 32'h8192_7f80, "sem take");
    wr(1'b1, 12'h8, 4'h8, 32'h0500_0000);
    rc(1'b0, 12'h8, 32'h0592_7f80, "sem release");
    // simultaneous claims: the first served wins
    fork
      wr(1'b0, 12'hc, 4'h8, 32'h8a00_0000);
      wr(1'b1, 12'hc, 4'h8, 32'h8b00_0000);
    join
    rc(1'b0, 12'hc, 32'h8a00_0000, "sem race");
    // local reset output and its minimum width
    wr(1'b0, 12'h4, 4'h8, 32'h8000_0000);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("lreset on", local_reset_out_n, 32'h0);
    wr(1'b1, 12'h4, 4'h8, 32'h0);
    repeat (gcsrmb_pkg::RST_MIN_CYC - 20) @(posedge ref_clk);
    #1;
    chk("lreset width", local_reset_out_n, 32'h0);
    repeat (40) @(posedge ref_clk);
    #1;
    chk("lreset off", local_reset_out_n, 32'h1);
    // second power-up reset with the strap low
    do_reset(1'b0);
    rc(1'b0, 12'h4, ctl(0, 0, 0, 4'h0, 4'h0), "strap low");
    rc(1'b1, 12'h8, 32'h0, "sem reset");
    rc(1'b0, 12'h10, 32'h0, "mailbox reset");
    wrap_up();
  end
endmodule : gcsrmb_top_tb
`default_nettype wire
